/* File: hw/lpwm_pkg.sv */
/*
  Shared constants for the link power and wake manager: register map,
  field positions, reset values, interface states and timing counts.
  Assumes a 40 MHz core clock; all cycle counts derive from that rate.
*/
package lpwm_pkg;

  // clock rate
  localparam int CORE_CLK_MHZ = 40;

  // times in their own units, then the cycle counts derived from them
  localparam int INACTIVE_THRESHOLD_NS = 2600;
  localparam int DISABLE_THRESHOLD_NS = 25000;
  localparam int WAKE_HALF_PERIOD_NS = 100;
  localparam int POWERUP_WAKE_US = 167;
  localparam int INACTIVE_THRESHOLD_CYC = (INACTIVE_THRESHOLD_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int DISABLE_THRESHOLD_CYC = (DISABLE_THRESHOLD_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int WAKE_HALF_PERIOD_CYC = (WAKE_HALF_PERIOD_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int POWERUP_WAKE_CYC = POWERUP_WAKE_US * CORE_CLK_MHZ;

  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS_OFS = 8'h04;

  // control register fields
  localparam int CTRL_LINK_CONTROL_BIT = 0;
  localparam int CTRL_CONTENDER_BIT = 1;
  localparam int CTRL_INT_WAKE_EN_BIT = 2;
  localparam logic CTRL_LINK_CONTROL_RST = 1'b1;
  localparam logic CTRL_CONTENDER_RST = 1'b0;
  localparam logic CTRL_INT_WAKE_EN_RST = 1'b0;

  // status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_WAKE_BIT = 3;
  localparam int STAT_INT_PEND_BIT = 4;
  localparam int STAT_PCLASS_LSB = 5;
  localparam int STAT_ACCESSIBLE_BIT = 8;

  // highest power class that triggers the power-up wake pulse
  localparam logic [2:0] PCLASS_WAKE_MAX = 3'h4;

  localparam int NUM_PORTS = 3;

  typedef enum logic [2:0] {
    LPWM_DISABLED = 3'b001,
    LPWM_RESET = 3'b010,
    LPWM_NORMAL = 3'b100
  } lpwm_ifc_state_e;

endpackage

/* File: hw/lpwm_lps_if.sv */
/*
  Carrier between the low-time filter and the top module.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface lpwm_lps_if;
  logic lps_inactive;
  logic lps_disabled;
  modport filt (output lps_inactive, output lps_disabled);
  modport ctrl (input lps_inactive, input lps_disabled);
endinterface

/* File: hw/lpwm_lps_filter.sv */
/*
  Measures how long the link power status input has stayed low and flags
  the inactive and disabled thresholds.
  Assumes the input is already synchronous to core_clk.
*/
`timescale 1ns/1ps
module lpwm_lps_filter #(
  parameter int RESET_CYC = lpwm_pkg::INACTIVE_THRESHOLD_CYC,
  parameter int DISABLE_CYC = lpwm_pkg::DISABLE_THRESHOLD_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic lps_level,
  lpwm_lps_if.filt flags
);
  import lpwm_pkg::*;

  localparam int CNT_W = $clog2(DISABLE_CYC + 2);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(DISABLE_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_RESET = CNT_W'(RESET_CYC);
  localparam logic [CNT_W-1:0] CNT_DISABLE = CNT_W'(DISABLE_CYC);

  logic [CNT_W-1:0] low_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // saturating low-time counter; any high sample restarts it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // starts saturated: no high seen yet, so the interface stays disabled
      // and the power-up wake window is not cut short by a phantom active
      low_cnt_reg <= CNT_MAX;
    end else if (lps_level) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != CNT_MAX) begin
      low_cnt_reg <= low_cnt_reg + CNT_W'(1);
    end
  end

  // strictly longer than the threshold counts; shorter dips stay active
  assign flags.lps_inactive = (low_cnt_reg > CNT_RESET);
  assign flags.lps_disabled = (low_cnt_reg > CNT_DISABLE);

endmodule

/* File: hw/lpwm_top.sv */
/*
  Link power and wake manager: derives the link interface state from the
  link power status input, gates link outputs, asks for a bus reset on
  leaving disabled, drives the wake square wave, and holds the strap and
  control bits. Assumes all inputs are synchronous to core_clk and that
  bus reset and packet events arrive as one-cycle pulses from the core.
*/
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module lpwm_top #(
  parameter int RESET_CYC = lpwm_pkg::INACTIVE_THRESHOLD_CYC,
  parameter int DISABLE_CYC = lpwm_pkg::DISABLE_THRESHOLD_CYC,
  parameter int WAKE_HALF_CYC = lpwm_pkg::WAKE_HALF_PERIOD_CYC,
  parameter int POWERUP_CYC = lpwm_pkg::POWERUP_WAKE_CYC,
  parameter int CTL_W = 2,
  parameter int DATA_OUT_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [lpwm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lpwm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lpwm_pkg::DATA_W-1:0] reg_rdata,
  input wire logic link_power_status_in,
  input wire logic link_request_in,
  output logic link_request_taken,
  input wire logic [CTL_W-1:0] core_ctl_in,
  input wire logic [DATA_OUT_W-1:0] core_data_in,
  output logic [CTL_W-1:0] control_lines,
  output logic [DATA_OUT_W-1:0] link_data_out,
  output logic link_clock_enable,
  output logic bus_reset_request,
  input wire logic bus_reset_seen,
  input wire logic linkon_packet_rx,
  input wire logic phy_interrupt,
  output logic link_wake_out,
  output logic link_accessible,
  output logic contender,
  input wire logic power_class_strap_0,
  input wire logic power_class_strap_1,
  input wire logic power_class_strap_2,
  output logic [2:0] power_class_default,
  input wire logic strobe_only_select_0,
  input wire logic strobe_only_select_1,
  input wire logic strobe_only_select_2,
  output logic [lpwm_pkg::NUM_PORTS-1:0] port_bilingual
);
  import lpwm_pkg::*;

  localparam int PU_W = $clog2(POWERUP_CYC + 1);
  localparam int HALF_W = $clog2(WAKE_HALF_CYC + 1);
  localparam logic [PU_W-1:0] PU_LOAD = PU_W'(POWERUP_CYC);
  localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(WAKE_HALF_CYC - 1);

  lpwm_lps_if lps_flags ();

  lpwm_ifc_state_e state_reg;
  lpwm_ifc_state_e state_next;
  logic link_ctrl_reg;
  logic contender_reg;
  logic int_wake_en_reg;
  logic int_pend_reg;
  logic wake_req_reg;
  logic [PU_W-1:0] pu_cnt_reg;
  logic straps_taken_reg;
  logic [HALF_W-1:0] half_cnt_reg;
  logic wave_reg;
  logic accessible_reg;
  logic llc_active;
  logic wake_on;
  logic wake_event;
  logic int_cond;
  logic wr_ctrl;
  logic wr_status;

  lpwm_lps_filter #(
    .RESET_CYC(RESET_CYC),
    .DISABLE_CYC(DISABLE_CYC)
  ) u_filter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .lps_level(link_power_status_in),
    .flags(lps_flags)
  );

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  assign wr_ctrl = reg_wr && addr_hit(reg_addr, REG_CTRL_OFS);
  assign wr_status = reg_wr && addr_hit(reg_addr, REG_STATUS_OFS);
  assign llc_active = !lps_flags.lps_inactive && link_ctrl_reg;
  assign int_cond = int_pend_reg && int_wake_en_reg;
  assign wake_event = linkon_packet_rx || (phy_interrupt && int_wake_en_reg);
  assign wake_on = wake_req_reg || (pu_cnt_reg != '0);

  ////////////////////////////////////////////////////////////////////////////
  // interface state; the control bit is deliberately not an input here
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LPWM_NORMAL: begin
        if (lps_flags.lps_inactive) begin
          state_next = LPWM_RESET;
        end
      end
      LPWM_RESET: begin
        if (lps_flags.lps_disabled) begin
          state_next = LPWM_DISABLED;
        end else if (!lps_flags.lps_inactive) begin
          state_next = LPWM_NORMAL;
        end
      end
      LPWM_DISABLED: begin
        if (!lps_flags.lps_inactive) begin
          state_next = LPWM_NORMAL;
        end
      end
      default: state_next = LPWM_DISABLED;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LPWM_DISABLED;
    end else begin
      state_reg <= state_next;
    end
  end

  // leaving disabled asks the core for a bus reset and marks the link reachable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_reset_request <= 1'b0;
      accessible_reg <= 1'b0;
    end else begin
      bus_reset_request <= (state_reg == LPWM_DISABLED) && (state_next == LPWM_NORMAL);
      if (state_next == LPWM_NORMAL) begin
        accessible_reg <= 1'b1;
      end else if (state_next == LPWM_DISABLED) begin
        accessible_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link-facing outputs, forced low outside normal; the clock enable stays high in reset and drops only in disabled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_lines <= '0;
      link_data_out <= '0;
      link_request_taken <= 1'b0;
      link_clock_enable <= 1'b0;
    end else begin
      control_lines <= (state_next == LPWM_NORMAL) ? core_ctl_in : '0;
      link_data_out <= (state_next == LPWM_NORMAL) ? core_data_in : '0;
      link_request_taken <= (state_next == LPWM_NORMAL) && link_request_in;
      link_clock_enable <= (state_next != LPWM_DISABLED);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // straps caught once after reset release; port modes follow the selects
  // continuously and never look at the interface state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      straps_taken_reg <= 1'b0;
      power_class_default <= 3'h0;
    end else if (!straps_taken_reg) begin
      straps_taken_reg <= 1'b1;
      power_class_default <= {power_class_strap_2, power_class_strap_1, power_class_strap_0};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_bilingual <= '0;
    end else begin
      port_bilingual <= ~{strobe_only_select_2, strobe_only_select_1, strobe_only_select_0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bank; contender has no path other than this write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_ctrl_reg <= CTRL_LINK_CONTROL_RST;
      contender_reg <= CTRL_CONTENDER_RST;
      int_wake_en_reg <= CTRL_INT_WAKE_EN_RST;
    end else if (wr_ctrl) begin
      link_ctrl_reg <= reg_wdata[CTRL_LINK_CONTROL_BIT];
      contender_reg <= reg_wdata[CTRL_CONTENDER_BIT];
      int_wake_en_reg <= reg_wdata[CTRL_INT_WAKE_EN_BIT];
    end
  end

  // sticky interrupt; a new interrupt wins over a write-one clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_pend_reg <= 1'b0;
    end else if (phy_interrupt) begin
      int_pend_reg <= 1'b1;
    end else if (wr_status && reg_wdata[STAT_INT_PEND_BIT]) begin
      int_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd && addr_hit(reg_addr, REG_CTRL_OFS)) begin
        reg_rdata[CTRL_LINK_CONTROL_BIT] <= link_ctrl_reg;
        reg_rdata[CTRL_CONTENDER_BIT] <= contender_reg;
        reg_rdata[CTRL_INT_WAKE_EN_BIT] <= int_wake_en_reg;
      end else if (reg_rd && addr_hit(reg_addr, REG_STATUS_OFS)) begin
        reg_rdata[STAT_STATE_LSB +: 3] <= state_reg;
        reg_rdata[STAT_WAKE_BIT] <= wake_on;
        reg_rdata[STAT_INT_PEND_BIT] <= int_pend_reg;
        reg_rdata[STAT_PCLASS_LSB +: 3] <= power_class_default;
        reg_rdata[STAT_ACCESSIBLE_BIT] <= accessible_reg;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      contender <= CTRL_CONTENDER_RST;
      link_accessible <= 1'b0;
    end else begin
      contender <= contender_reg;
      link_accessible <= accessible_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake request; a fresh event beats a bus reset in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_req_reg <= 1'b0;
    end else if (llc_active) begin
      wake_req_reg <= 1'b0;
    end else if (wake_event) begin
      wake_req_reg <= 1'b1;
    end else if (bus_reset_seen && !int_cond) begin
      wake_req_reg <= 1'b0;
    end
  end

  // power-up wake window, loaded on the first cycle after reset release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_cnt_reg <= '0;
    end else if (!straps_taken_reg) begin
      pu_cnt_reg <= ({power_class_strap_2, power_class_strap_1, power_class_strap_0}
                     <= PCLASS_WAKE_MAX) ? PU_LOAD : '0;
    end else if (llc_active) begin
      pu_cnt_reg <= '0;
    end else if (pu_cnt_reg != '0) begin
      pu_cnt_reg <= pu_cnt_reg - PU_W'(1);
    end
  end

  // square wave while asserted; static low otherwise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_reg <= '0;
      wave_reg <= 1'b0;
      link_wake_out <= 1'b0;
    end else if (!wake_on) begin
      half_cnt_reg <= '0;
      wave_reg <= 1'b0;
      link_wake_out <= 1'b0;
    end else begin
      if (half_cnt_reg == HALF_LAST) begin
        half_cnt_reg <= '0;
        wave_reg <= !wave_reg;
      end else begin
        half_cnt_reg <= half_cnt_reg + HALF_W'(1);
      end
      link_wake_out <= !wave_reg;
    end
  end

endmodule

/* File: bench/lpwm_top_sva.sv */
/*
  Port checker for lpwm_top, bound into it.
  Assumes one core clock domain and the short counts used in simulation.
*/
`timescale 1ns/1ps
module lpwm_chk #(
  parameter int RESET_CYC = 4,
  parameter int DISABLE_CYC = 20,
  parameter int CTL_W = 2,
  parameter int DATA_OUT_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_power_status_in,
  input wire logic link_request_taken,
  input wire logic [CTL_W-1:0] core_ctl_in,
  input wire logic [DATA_OUT_W-1:0] core_data_in,
  input wire logic [CTL_W-1:0] control_lines,
  input wire logic [DATA_OUT_W-1:0] link_data_out,
  input wire logic link_clock_enable,
  input wire logic bus_reset_request,
  input wire logic bus_reset_seen,
  input wire logic linkon_packet_rx,
  input wire logic link_wake_out,
  input wire logic strobe_only_select_0,
  input wire logic strobe_only_select_1,
  input wire logic strobe_only_select_2,
  input wire logic [lpwm_pkg::NUM_PORTS-1:0] port_bilingual
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////
  // low samples seen; starts saturated since reset means disabled
  logic [9:0] low_cnt_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg <= 10'h3FF;
    end else if (link_power_status_in) begin
      low_cnt_reg <= 10'h000;
    end else if (low_cnt_reg != 10'h3FF) begin
      low_cnt_reg <= low_cnt_reg + 10'h001;
    end
  end
  property p_reset_zero;
    low_cnt_reg > RESET_CYC + 1 && low_cnt_reg <= DISABLE_CYC + 1 |-> link_clock_enable
      && control_lines == '0 && link_data_out == '0 && !link_request_taken;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset state outputs");
  property p_disable_clk;
    low_cnt_reg > DISABLE_CYC + 1 |-> !link_clock_enable && control_lines == '0;
  endproperty
  a_disable_clk: assert property (p_disable_clk) else $error("disabled state");
  property p_short_low;
    link_power_status_in ##1 !link_power_status_in [*4] |=> link_data_out == $past(core_data_in);
  endproperty
  a_short_low: assert property (p_short_low) else $error("short low dropped data");
  property p_resume;
    link_power_status_in |=> ##1 (link_clock_enable && control_lines == $past(core_ctl_in));
  endproperty
  a_resume: assert property (p_resume) else $error("not normal after active");
  property p_bus_reset;
    $rose(link_clock_enable) |-> ##[0:1] bus_reset_request;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("no bus reset");
  property p_wake_half;
    link_wake_out ##1 link_wake_out |=> !link_wake_out;
  endproperty
  a_wake_half: assert property (p_wake_half) else $error("wake held static");
  property p_wake_event;
    linkon_packet_rx && !link_clock_enable && !bus_reset_seen && !link_power_status_in
      ##1 !link_power_status_in [*2] |-> ##[0:2] link_wake_out;
  endproperty
  a_wake_event: assert property (p_wake_event) else $error("wake missing");
  property p_port_mode;
    rst_n |=> port_bilingual ==
      ~$past({strobe_only_select_2, strobe_only_select_1, strobe_only_select_0});
  endproperty
  a_port_mode: assert property (p_port_mode) else $error("port mode");
endmodule
bind lpwm_top lpwm_chk #(.RESET_CYC(RESET_CYC), .DISABLE_CYC(DISABLE_CYC), .CTL_W(CTL_W),
  .DATA_OUT_W(DATA_OUT_W)) u_chk (.*);

/* File: bench/lpwm_llc_model.sv */
/*
  Link-layer controller model: drives power status and link request.
  Assumes the bench commands power and whether a wake powers it up.
*/
`timescale 1ns/1ps
module lpwm_llc_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic power_cmd,
  input wire logic wake_reply,
  input wire logic link_wake_out,
  output logic link_power_status_in,
  output logic link_request_in
);
  //////////////////////////////////////////////////////////////
  logic [1:0] req_pat_reg;
  // request line wanders every cycle, so a gate stuck open shows up
  assign link_request_in = req_pat_reg[0];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_power_status_in <= 1'b0;
      req_pat_reg <= 2'h0;
    end else begin
      req_pat_reg <= req_pat_reg + 2'h1;
      if (power_cmd || (wake_reply && link_wake_out)) begin
        link_power_status_in <= 1'b1;
      end else if (!wake_reply) begin
        link_power_status_in <= 1'b0;
      end
    end
  end
endmodule

/* File: bench/test_link_power_wake_manager.sv */
/*
  Self-checking bench for lpwm_top with the controller model.
  Assumes short simulation counts: 4, 20, 2 and 50 cycles.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); \
  end \
end
module test_link_power_wake_manager;
  import lpwm_pkg::*;
  logic core_clk, rst_n, reg_wr, reg_rd, link_power_status_in, link_request_in;
  logic [7:0] reg_addr, core_data_in, link_data_out;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0] core_ctl_in, control_lines;
  logic [2:0] power_class_default, port_bilingual;
  logic link_request_taken, link_clock_enable, bus_reset_request, bus_reset_seen;
  logic linkon_packet_rx, phy_interrupt, link_wake_out, link_accessible, contender;
  logic power_class_strap_0, power_class_strap_1, power_class_strap_2;
  logic strobe_only_select_0, strobe_only_select_1, strobe_only_select_2;
  logic power_cmd, wake_reply;
  int tests_run = 0;
  int n_fail = 0;
  lpwm_top #(.RESET_CYC(4), .DISABLE_CYC(20), .WAKE_HALF_CYC(2), .POWERUP_CYC(50)) u_dut (.*);
  lpwm_llc_model u_llc (.*);
  //////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    `CHK(reg_rdata & m, e)
  endtask
  task automatic ev(input logic [2:0] m);
    {bus_reset_seen, phy_interrupt, linkon_packet_rx} <= m;
    @(posedge core_clk);
    {bus_reset_seen, phy_interrupt, linkon_packet_rx} <= 3'h0;
  endtask
  // skips two edges: the wake output trails its request by a cycle
  task automatic wk(input logic exp);
    int h;
    int r;
    logic p;
    h = 0;
    r = 0;
    p = 1'b0;
    repeat (2) @(posedge core_clk);
    repeat (16) begin
      @(posedge core_clk);
      h += (link_wake_out === 1'b1);
      r += (link_wake_out === 1'b1 && !p);
      p = link_wake_out;
    end
    `CHK(h != 0, exp)
    if (exp) `CHK(r > 1, 1'b1)
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  task automatic t_boot;
    rc(REG_CTRL_OFS, 32'hFFFFFFFF, 32'h1);
    rc(REG_STATUS_OFS, 32'h1F7, 32'h61);
    rc(8'h10, 32'hFFFFFFFF, 32'h0);
    `CHK(power_class_default, 3'h3)
    `CHK(port_bilingual, 3'h5)
    {strobe_only_select_2, strobe_only_select_1, strobe_only_select_0} <= 3'h5;
    repeat (3) @(posedge core_clk);
    `CHK(port_bilingual, 3'h2)
    wk(1'b1);
    repeat (30) @(posedge core_clk);
    wk(1'b0);
    $display("t_boot done");
  endtask
  task automatic t_resume;
    int n;
    n = 0;
    power_cmd <= 1'b1;
    repeat (6) begin
      @(posedge core_clk);
      n += (bus_reset_request === 1'b1);
    end
    `CHK(n, 1)
    `CHK(link_clock_enable, 1'b1)
    `CHK(link_accessible, 1'b1)
    rc(REG_STATUS_OFS, 32'h107, 32'h104);
    n = 0;
    repeat (8) begin
      @(posedge core_clk);
      n += (link_request_taken === 1'b1);
    end
    `CHK(n != 0, 1'b1)
    wr(REG_CTRL_OFS, 32'h0);
    core_data_in <= 8'h3C;
    repeat (2) @(posedge core_clk);
    `CHK(link_data_out, 8'h3C)
    rc(REG_STATUS_OFS, 32'h7, 32'h4);
    wr(REG_CTRL_OFS, 32'h1);
    $display("t_resume done");
  endtask
  task automatic t_low;
    power_cmd <= 1'b0;
    repeat (4) @(posedge core_clk);
    power_cmd <= 1'b1;
    repeat (4) begin
      @(posedge core_clk);
      `CHK(link_data_out, 8'h3C)
    end
    power_cmd <= 1'b0;
    repeat (12) @(posedge core_clk);
    `CHK({control_lines, link_data_out, link_clock_enable}, 11'h1)
    rc(REG_STATUS_OFS, 32'h7, 32'h2);
    repeat (20) @(posedge core_clk);
    `CHK(link_clock_enable, 1'b0)
    `CHK(link_accessible, 1'b0)
    rc(REG_STATUS_OFS, 32'h107, 32'h1);
    $display("t_low done");
  endtask
  task automatic t_wake;
    ev(3'h1);
    wk(1'b1);
    ev(3'h4);
    wk(1'b0);
    ev(3'h2);
    wk(1'b0);
    wr(REG_CTRL_OFS, 32'h5);
    ev(3'h2);
    wk(1'b1);
    ev(3'h4);
    wk(1'b1);
    wr(REG_STATUS_OFS, 32'h10);
    ev(3'h4);
    wk(1'b0);
    wr(REG_CTRL_OFS, 32'h4);
    power_cmd <= 1'b1;
    repeat (4) @(posedge core_clk);
    ev(3'h1);
    wk(1'b1);
    wr(REG_CTRL_OFS, 32'h7);
    wk(1'b0);
    `CHK(contender, 1'b1)
    wr(REG_CTRL_OFS, 32'h5);
    repeat (2) @(posedge core_clk);
    `CHK(contender, 1'b0)
    power_cmd <= 1'b0;
    repeat (30) @(posedge core_clk);
    wake_reply <= 1'b1;
    ev(3'h1);
    repeat (12) @(posedge core_clk);
    `CHK(link_clock_enable, 1'b1)
    wk(1'b0);
    $display("t_wake done");
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    complete_run;
  end
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, bus_reset_seen, phy_interrupt, linkon_packet_rx} = 5'h00;
    {power_cmd, wake_reply, reg_addr, reg_wdata} = 42'h0;
    {core_ctl_in, core_data_in} = 10'h2A5;
    {power_class_strap_2, power_class_strap_1, power_class_strap_0} = 3'h3;
    {strobe_only_select_2, strobe_only_select_1, strobe_only_select_0} = 3'h2;
    repeat (4) @(posedge core_clk);
    `CHK(link_clock_enable, 1'b0)
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_boot;
    t_resume;
    t_low;
    t_wake;
    complete_run;
  end
endmodule
